/* core/sss_shift_store.sv */
/*
  Eight-stage serial shift register with storage latches, three-state parallel
  outputs, two cascade outputs and a snapshot FIFO.
  Assumes shift clock, data, strobe and enable arrive asynchronously from pins
  and are sampled on clock_i, so the shift clock must be well below 5 MHz.
*/
// Operation
// (R1) Eight shift stages move the serial input one stage on every rising shift-clock edge.
// (R2) While strobe is high every stage is copied into its storage latch.
// (R3) The parallel outputs carry the latches only while output enable is high and float otherwise.
// (R4) The fast cascade output shows the last stage and changes on the rising shift-clock edge.
// (R5) The late cascade output shows the same bit but changes on the following falling edge.
// (R6) Two serial outputs exist so a chained device can take either one as its serial input.
// (R7) While strobe is low the latches keep their contents whatever the stages do.
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Snapshot FIFO
// ------------------------------------------------------------------
module sss_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  // Fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // Drain side
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wr_ptr;
    logic [AW:0]                 rd_ptr;
  } sss_fifo_state_type;

  sss_fifo_state_type state_ff;
  sss_fifo_state_type nxt_state;
  logic               empty;
  logic               full;

  assign empty       = state_ff.wr_ptr == state_ff.rd_ptr;
  assign full        = (state_ff.wr_ptr[AW-1:0] == state_ff.rd_ptr[AW-1:0]) &&
                       (state_ff.wr_ptr[AW] != state_ff.rd_ptr[AW]);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = state_ff.mem[state_ff.rd_ptr[AW-1:0]];

  always_comb begin
    nxt_state = state_ff;
    if (in_valid_i && !full) begin
      nxt_state.mem[state_ff.wr_ptr[AW-1:0]] = in_data_i;
      nxt_state.wr_ptr = state_ff.wr_ptr + 1'b1;
    end
    if (out_ready_i && !empty) begin
      nxt_state.rd_ptr = state_ff.rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end
endmodule // sss_fifo

// ------------------------------------------------------------------
// Shift-and-store register
// ------------------------------------------------------------------
module sss_shift_store #(
  parameter int unsigned SNAP_DEPTH = sss_pkg::SNAP_DEPTH
) (
  // Clock and reset
  input  wire logic                       clock_i,
  input  wire logic                       rst_i,
  // Control pins from the driving logic
  input  wire logic                       shift_clk_i,
  input  wire logic                       serial_data_i,
  input  wire logic                       strobe_i,
  input  wire logic                       out_enable_i,
  // Parallel three-state outputs
  output logic [sss_pkg::STAGES-1:0]      par_data_o,
  output logic [sss_pkg::STAGES-1:0]      par_oe_o,
  // Cascade outputs
  output logic                            cascade_serial_out_o,
  output logic                            cascade_serial_late_o,
  // Snapshot stream
  output logic                            snap_valid_o,
  output logic [sss_pkg::STAGES-1:0]      snap_data_o,
  input  wire logic                       snap_ready_i,
  output logic                            snap_room_o
);
  typedef struct packed {
    logic [1:0]                 sclk_sync;
    logic                       sclk_prev;
    logic [1:0]                 data_sync;
    logic [1:0]                 stb_sync;
    logic                       stb_prev;
    logic [1:0]                 oe_sync;
    logic [sss_pkg::STAGES-1:0] stage;
    logic [sss_pkg::STAGES-1:0] latch;
    logic                       late;
  } sss_state_type;

  sss_state_type state_ff;
  sss_state_type nxt_state;
  logic          sclk_rise;
  logic          sclk_fall;
  logic          stb_high;
  logic          snap_push;

  // ----------------------------------------------------------------
  // Edge detection on the second synchroniser stage
  // ----------------------------------------------------------------
  assign sclk_rise = state_ff.sclk_sync[1] && !state_ff.sclk_prev;
  assign sclk_fall = !state_ff.sclk_sync[1] && state_ff.sclk_prev;
  assign stb_high  = state_ff.stb_sync[1];
  assign snap_push = stb_high && !state_ff.stb_prev;

  always_comb begin
    nxt_state              = state_ff;
    // Pins pass two flops; only the second one feeds any logic
    nxt_state.sclk_sync    = {state_ff.sclk_sync[0], shift_clk_i};
    nxt_state.data_sync    = {state_ff.data_sync[0], serial_data_i};
    nxt_state.stb_sync     = {state_ff.stb_sync[0], strobe_i};
    nxt_state.oe_sync      = {state_ff.oe_sync[0], out_enable_i};
    nxt_state.sclk_prev    = state_ff.sclk_sync[1];
    nxt_state.stb_prev     = state_ff.stb_sync[1];
    if (sclk_rise) begin
      nxt_state.stage = {state_ff.stage[sss_pkg::STAGES-2:0], state_ff.data_sync[1]}; // R1 R4
    end
    // Transparent: a shift in the same cycle reaches the latches at once
    if (stb_high) begin
      nxt_state.latch = nxt_state.stage; // R2 R7
    end
    if (sclk_fall) begin
      nxt_state.late = state_ff.stage[sss_pkg::STAGES-1]; // R5
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign par_data_o            = state_ff.latch;
  assign par_oe_o              = {sss_pkg::STAGES{state_ff.oe_sync[1]}}; // R3
  assign cascade_serial_out_o  = state_ff.stage[sss_pkg::STAGES-1]; // R4 R6
  assign cascade_serial_late_o = state_ff.late; // R5 R6

  // Each strobe rise queues the captured word; a full FIFO drops it
  sss_fifo #(
    .WIDTH (sss_pkg::STAGES),
    .DEPTH (SNAP_DEPTH)
  ) u_snap (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .in_valid_i  (snap_push),
    .in_data_i   (nxt_state.latch),
    .in_ready_o  (snap_room_o),
    .out_valid_o (snap_valid_o),
    .out_data_o  (snap_data_o),
    .out_ready_i (snap_ready_i)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  chk_shift_advance: assert property (sclk_rise |=> // R1
    state_ff.stage == {$past(state_ff.stage[6:0]), $past(state_ff.data_sync[1])})
    else $error("stages did not advance on shift clock rise");
  chk_shift_idle: assert property (!sclk_rise |=> $stable(state_ff.stage)) // R1
    else $error("stages moved without a shift clock rise");
  chk_latch_copy: assert property (stb_high |=> par_data_o == state_ff.stage) // R2
    else $error("latches did not follow stages under strobe");
  chk_latch_hold: assert property (!stb_high |=> $stable(par_data_o)) // R7
    else $error("latches changed with strobe low");
  chk_oe_drive: assert property ( // R3
    par_oe_o == {sss_pkg::STAGES{$past(out_enable_i, 2)}})
    else $error("output enable did not follow the pin after two cycles");
  chk_fast_cascade: assert property (sclk_rise |=> // R4
    cascade_serial_out_o == $past(state_ff.stage[6]))
    else $error("fast cascade output wrong after rise");
  chk_late_cascade: assert property (sclk_fall |=> // R5
    cascade_serial_late_o == $past(cascade_serial_out_o))
    else $error("late cascade output wrong after fall");
  chk_late_stable: assert property (!sclk_fall |=> $stable(cascade_serial_late_o)) // R5
    else $error("late cascade output changed without a fall");
  chk_chain_pair: assert property (sclk_fall |=> // R6
    cascade_serial_late_o == cascade_serial_out_o)
    else $error("cascade outputs disagree after fall");

  chk_snap_word: assert property (snap_push && !snap_valid_o |=> // R2
    snap_data_o == $past(nxt_state.latch))
    else $error("snapshot head differs from the strobed word");

  // Scenario covers
  cov_shift_strobe: cover property (sclk_rise && stb_high);
  cov_late_update: cover property (sclk_fall ##1 cascade_serial_late_o);
  cov_snap_full: cover property (!snap_room_o);
  cov_hold_shift: cover property (!stb_high && sclk_rise);
  cov_oe_float: cover property ($fell(state_ff.oe_sync[1]));
endmodule // sss_shift_store

/* core/sss_pkg.sv */
/*
  Constants for the serial shift-and-store register.
  Assumes a single 10 MHz system clock and an active-high asynchronous reset.
*/
package sss_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned STAGES     = 8;
  localparam int unsigned SNAP_DEPTH = 8;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [STAGES-1:0] STAGE_RST = 8'h00;
  localparam logic [STAGES-1:0] LATCH_RST = 8'h00;
  localparam logic              SYNC_RST  = 1'h0;
  localparam logic              CASC_RST  = 1'h0;
  localparam logic [3:0]        PTR_RST   = 4'h0;
endpackage

/* bench/sss_ctrl_model.sv */
/* Model of the controlling logic: shift clock, data, strobe and enable.
   Assumes callers enter its tasks just after a clock_i rising edge. */
`timescale 1ns/1ps
module sss_ctrl_model (
  // Clock
  input  wire logic clock_i,
  // Pins toward the register
  output logic      shift_clk_o,
  output logic      serial_data_o,
  output logic      strobe_o,
  output logic      out_enable_o
);
  initial begin
    {shift_clk_o, serial_data_o, strobe_o, out_enable_o} = 4'h0;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic set_oe(input logic e);
    out_enable_o = e;
  endtask
  // Data settles long before the rise; each phase exceeds three cycles
  task automatic edge_up(input logic b);
    serial_data_o = b;
    wait_cyc(5);
    shift_clk_o = 1'b1;
    wait_cyc(6);
  endtask
  task automatic edge_down();
    shift_clk_o = 1'b0;
    wait_cyc(6);
  endtask
  // First bit sent ends in the last stage
  task automatic send_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      edge_up(v[i]);
      edge_down();
    end
  endtask
  task automatic pulse_strobe();
    strobe_o = 1'b1;
    wait_cyc(5);
    strobe_o = 1'b0;
    wait_cyc(5);
  endtask
endmodule // sss_ctrl_model

/* bench/tb_serial_shift_store_register.sv */
/* Self-checking bench for the shift-and-store register.
   Assumes sss_pkg, the design and sss_ctrl_model are compiled first. */
`timescale 1ns/1ps
module tb_serial_shift_store_register;
  logic                         clock_i, rst_i, snap_ready_i, shift_clk, sdata, strobe, oe;
  logic [sss_pkg::STAGES-1:0]   par_data_o, par_oe_o, snap_data_o, lat;
  logic                         cso, csl, snap_valid_o, snap_room_o;
  int                           fails, num_checks, n;
  // Rows: shifted value, strobe pulsed, enable level
  logic [9:0] rows [4] = '{10'h297, 10'h0f1, 10'h206, 10'h1fb};
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  sss_shift_store #(.SNAP_DEPTH(8)) uut (
    .clock_i, .rst_i, .shift_clk_i(shift_clk), .serial_data_i(sdata), .strobe_i(strobe),
    .out_enable_i(oe), .par_data_o, .par_oe_o, .cascade_serial_out_o(cso),
    .cascade_serial_late_o(csl), .snap_valid_o, .snap_data_o, .snap_ready_i, .snap_room_o);
  sss_ctrl_model ctl (.clock_i, .shift_clk_o(shift_clk), .serial_data_o(sdata),
    .strobe_o(strobe), .out_enable_o(oe));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    if (fails == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    fails = 0;
    num_checks = 0;
    rst_i = 1'b1;
    snap_ready_i = 1'b1;
    lat = 8'h00;
    ctl.wait_cyc(3);
    chk(par_data_o, 8'h00);
    chk({cso, csl, snap_valid_o, snap_room_o}, 8'h01);
    rst_i = 1'b0;
    ctl.wait_cyc(2);
    foreach (rows[i]) begin
      ctl.set_oe(rows[i][0]);
      ctl.send_byte(rows[i][9:2]);
      chk(cso, rows[i][9]);
      chk(csl, rows[i][9]);
      chk(par_data_o, lat);
      if (rows[i][1]) begin
        ctl.pulse_strobe();
        lat = rows[i][9:2];
      end
      chk(par_data_o, lat);
      chk(par_oe_o, {8{rows[i][0]}});
    end
    // Fast output moves on the rise, late one only after the fall
    ctl.edge_up(1'b1);
    chk({cso, csl}, 2'b10);
    ctl.edge_down();
    chk({cso, csl}, 2'b11);
    // Fill the snapshot queue with the drain stalled, then empty it
    snap_ready_i = 1'b0;
    repeat (9) ctl.pulse_strobe();
    chk(par_data_o, 8'hfd);
    chk(snap_room_o, 1'b0);
    chk(snap_data_o, 8'hfd);
    snap_ready_i = 1'b1;
    n = 0;
    repeat (20) begin
      n += int'(snap_valid_o);
      ctl.wait_cyc(1);
    end
    chk(n[7:0], 8'h08);
    chk({snap_valid_o, snap_room_o}, 2'b01);
    // Strobe held through a shift: latches follow at once, then hold
    ctl.strobe_o = 1'b1;
    ctl.edge_up(1'b0);
    chk(par_data_o, 8'hfa);
    ctl.strobe_o = 1'b0;
    ctl.edge_down();
    chk(par_data_o, 8'hfa);
    rst_i = 1'b1;
    ctl.wait_cyc(1);
    chk(par_data_o, 8'h00);
    conclude();
  end
  initial begin
    #400000;
    fails++;
    conclude();
  end
endmodule // tb_serial_shift_store_register
